// file: hdl/tpio_top.sv
// Pin function control for timer channels 1 and 2, APB register access.
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ns
module tpio_top (
	input  wire logic        sys_clk,  // System clock, 25 MHz.
	input  wire logic        rst_b,    // Sync reset, active low.
	input  wire logic        psel,     // APB select.
	input  wire logic        penable,  // APB enable.
	input  wire logic        pwrite,   // APB write.
	input  wire logic [11:0] paddr,    // APB byte address.
	input  wire logic [31:0] pwdata,   // APB write data.
	input  wire logic [15:0] counter,  // Timer count value.
	input  wire logic [3:0]  pin_in,   // Pins: a1, b1, a2, b2.
	output logic [31:0]      prdata,   // APB read data.
	output logic             pready,   // APB ready.
	output logic             pslverr,  // APB error.
	output logic [3:0]       pin_out,  // Pin drive levels.
	output logic [3:0]       pin_oe    // Pin output enables.
);

	// ****************************************************************
	// Field decoding
	// ****************************************************************

	// Decodes one 4-bit field; ch2 ignores bit 2 when capturing.
	function automatic tpio_pkg::tpio_cfg_type decode(
		input logic [3:0] f,
		input logic       ch2
	);
		tpio_pkg::tpio_cfg_type c;
		c.capture    = f[3];
		c.init_level = f[2];
		if (f[3]) begin
			if (f[2] && !ch2) begin
				c.fn = tpio_pkg::FN_PROHIBITED;
			end else if (f[1]) begin
				c.fn = tpio_pkg::FN_CAP_BOTH;
			end else if (f[0]) begin
				c.fn = tpio_pkg::FN_CAP_FALL;
			end else begin
				c.fn = tpio_pkg::FN_CAP_RISE;
			end
		end else begin
			case (f[1:0])
				2'h1:    c.fn = tpio_pkg::FN_CMP_LOW;
				2'h2:    c.fn = tpio_pkg::FN_CMP_HIGH;
				2'h3:    c.fn = tpio_pkg::FN_CMP_TOGGLE;
				default: c.fn = tpio_pkg::FN_OFF;
			endcase
		end
		return c;
	endfunction

	logic [7:0]             io_control_ch1;
	logic [7:0]             io_control_ch2;
	logic [15:0]            gen_value [tpio_pkg::NUM_GEN];
	logic [3:0]             pin_drv;
	logic [3:0]             pin_en;
	logic                   wr;
	logic                   rd;
	logic                   wr_ch1;
	logic                   wr_ch2;
	logic [3:0]             fields [tpio_pkg::NUM_GEN];
	tpio_pkg::tpio_cfg_type cfgs   [tpio_pkg::NUM_GEN];
	logic [3:0]             loads;
	logic [3:0]             gen_wr;

	assign wr     = psel && penable && pwrite;
	assign rd     = psel && penable && !pwrite;
	assign wr_ch1 = wr && (paddr == tpio_pkg::OFF_IO_CONTROL_CH1);
	assign wr_ch2 = wr && (paddr == tpio_pkg::OFF_IO_CONTROL_CH2);

	// ****************************************************************
	// Control registers
	// ****************************************************************

	// Channel control registers, cleared by reset.
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			io_control_ch1 <= tpio_pkg::IO_CONTROL_RESET;
			io_control_ch2 <= tpio_pkg::IO_CONTROL_RESET;
		end else begin
			if (wr_ch1) begin
				io_control_ch1 <= pwdata[7:0];
			end
			if (wr_ch2) begin
				io_control_ch2 <= pwdata[7:0];
			end
		end
	end

	// Nibble split: low field drives register A, high field B.
	assign fields[0] = io_control_ch1[tpio_pkg::FIELD_A_LSB +: 4];
	assign fields[1] = io_control_ch1[tpio_pkg::FIELD_B_LSB +: 4];
	assign fields[2] = io_control_ch2[tpio_pkg::FIELD_A_LSB +: 4];
	assign fields[3] = io_control_ch2[tpio_pkg::FIELD_B_LSB +: 4];

	// Marks the cycle after a control write so the initial level loads.
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			loads <= 4'h0;
		end else begin
			loads <= {wr_ch2, wr_ch2, wr_ch1, wr_ch1};
		end
	end

	// ****************************************************************
	// Pin units
	// ****************************************************************

	// One unit per general register and pin.
	genvar gi;
	generate
		for (gi = 0; gi < tpio_pkg::NUM_GEN; gi++) begin : g_unit
			assign cfgs[gi]   = decode(fields[gi], gi >= 2);
			assign gen_wr[gi] = wr && (paddr ==
				tpio_pkg::OFF_GEN_BASE + 12'(4 * gi));
			tpio_pin_unit u_unit (
				.sys_clk   (sys_clk),
				.rst_b     (rst_b),
				.cfg       (cfgs[gi]),
				.cfg_load  (loads[gi]),
				.counter   (counter),
				.gen_wr    (gen_wr[gi]),
				.gen_wdata (pwdata[15:0]),
				.pin_in    (pin_in[gi]),
				.gen_value (gen_value[gi]),
				.pin_out   (pin_drv[gi]),
				.pin_oe    (pin_en[gi])
			);
		end
	endgenerate

	// Pin outputs registered once more at the top.
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pin_out <= 4'h0;
			pin_oe  <= 4'h0;
		end else begin
			pin_out <= pin_drv;
			pin_oe  <= pin_en;
		end
	end

	// ****************************************************************
	// APB slave
	// ****************************************************************

	// Answers in the first access cycle; unmapped gives an error.
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (psel && !penable) begin
				if (paddr == tpio_pkg::OFF_IO_CONTROL_CH1) begin
					prdata <= {24'h00_0000, io_control_ch1};
				end else if (paddr == tpio_pkg::OFF_IO_CONTROL_CH2) begin
					prdata <= {24'h00_0000, io_control_ch2};
				end else if (paddr == tpio_pkg::OFF_PIN_STATUS) begin
					prdata <= {24'h00_0000, pin_en, pin_drv};
				end else if (paddr == tpio_pkg::OFF_COUNTER) begin
					prdata <= {16'h0000, counter};
				end else if (paddr[11:4] == tpio_pkg::OFF_GEN_BASE[11:4]
					&& paddr[1:0] == 2'h0) begin
					prdata <= {16'h0000, gen_value[paddr[3:2]]};
				end else begin
					pslverr <= 1'b1;
				end
			end
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************

	// A control write that sets field a of channel 1 to start low.
	sequence s_ctl_write;
		wr_ch1 && pwdata[3:0] == 4'h1;
	endsequence

	// A control write that sets field b of channel 1 to start high.
	sequence s_b_high_write;
		wr_ch1 && pwdata[7:4] == 4'h5;
	endsequence

	// Reset clears both control registers.
	property p_reset_zero;
		@(posedge sys_clk) !rst_b |=> io_control_ch1 == 8'h00
			&& io_control_ch2 == 8'h00;
	endproperty
	a_reset_zero: assert property (p_reset_zero)
		else $error("Control not zero after reset.");

	// Reset leaves every pin undriven and the bus idle.
	property p_reset_pins;
		@(posedge sys_clk) !rst_b |=> pin_oe == 4'h0 && !pready;
	endproperty
	a_reset_pins: assert property (p_reset_pins)
		else $error("Pins driven after reset.");

	// The initial level reaches the unit two edges after the write.
	property p_init_low;
		@(posedge sys_clk) disable iff (!rst_b)
			s_ctl_write ##1 1'b1 |=> pin_drv[0] == 1'b0;
	endproperty
	a_init_low: assert property (p_init_low)
		else $error("Initial level not low.");

	// Code 0101 starts the pin high after the load cycle.
	property p_init_high;
		@(posedge sys_clk) disable iff (!rst_b)
			wr_ch1 && pwdata[3:0] == 4'h5 |=> ##1 pin_drv[0] == 1'b1;
	endproperty
	a_init_high: assert property (p_init_high)
		else $error("Initial level not high.");

	// The high field owns pin b: its initial level lands on unit 1.
	property p_b_init_high;
		@(posedge sys_clk) disable iff (!rst_b)
			s_b_high_write ##1 1'b1 |=> pin_drv[1] == 1'b1;
	endproperty
	a_b_init_high: assert property (p_b_init_high)
		else $error("Field b did not set pin b.");

	// A disabled compare field never drives its pin.
	property p_off_no_drive;
		@(posedge sys_clk) disable iff (!rst_b)
			fields[0][1:0] == 2'h0 && !fields[0][3] |=> !pin_en[0];
	endproperty
	a_off_no_drive: assert property (p_off_no_drive)
		else $error("Disabled pin driven.");

	// A match outside the load cycle drives the pin low.
	property p_cmp_low;
		@(posedge sys_clk) disable iff (!rst_b)
			cfgs[0].fn == tpio_pkg::FN_CMP_LOW && !loads[0]
			&& counter == gen_value[0] |=> !pin_drv[0];
	endproperty
	a_cmp_low: assert property (p_cmp_low)
		else $error("Match did not drive low.");

	// A match outside the load cycle drives the pin high.
	property p_cmp_high;
		@(posedge sys_clk) disable iff (!rst_b)
			cfgs[1].fn == tpio_pkg::FN_CMP_HIGH && !loads[1]
			&& counter == gen_value[1] |=> pin_drv[1];
	endproperty
	a_cmp_high: assert property (p_cmp_high)
		else $error("Match did not drive high.");

	// A match outside the load cycle inverts the pin.
	property p_cmp_toggle;
		@(posedge sys_clk) disable iff (!rst_b)
			cfgs[2].fn == tpio_pkg::FN_CMP_TOGGLE && !loads[2]
			&& counter == gen_value[2] |=> pin_drv[2] != $past(pin_drv[2]);
	endproperty
	a_cmp_toggle: assert property (p_cmp_toggle)
		else $error("Match did not toggle.");

	// A rising edge on pin b of channel 1 latches the count.
	property p_cap_rise;
		@(posedge sys_clk) disable iff (!rst_b)
			cfgs[1].fn == tpio_pkg::FN_CAP_RISE && pin_in[1]
			&& !$past(pin_in[1]) |=> gen_value[1] == $past(counter);
	endproperty
	a_cap_rise: assert property (p_cap_rise)
		else $error("Rising capture missed.");

	// A falling edge on pin a of channel 1 latches the count.
	property p_cap_fall;
		@(posedge sys_clk) disable iff (!rst_b)
			cfgs[0].fn == tpio_pkg::FN_CAP_FALL && !pin_in[0]
			&& $past(pin_in[0]) |=> gen_value[0] == $past(counter);
	endproperty
	a_cap_fall: assert property (p_cap_fall)
		else $error("Falling capture missed.");

	// Either edge on pin b of channel 2 latches the count.
	property p_cap_both;
		@(posedge sys_clk) disable iff (!rst_b)
			cfgs[3].fn == tpio_pkg::FN_CAP_BOTH
			&& pin_in[3] != $past(pin_in[3])
			|=> gen_value[3] == $past(counter);
	endproperty
	a_cap_both: assert property (p_cap_both)
		else $error("Two-edge capture missed.");

	// Channel 2 selects capture whatever bit 2 holds.
	property p_ch2_ignore;
		@(posedge sys_clk) disable iff (!rst_b)
			fields[3][3] && fields[3][1]
			|-> cfgs[3].fn == tpio_pkg::FN_CAP_BOTH;
	endproperty
	a_ch2_ignore: assert property (p_ch2_ignore)
		else $error("Channel 2 bit 2 not ignored.");

	// A capture field leaves its pin to the outside driver.
	property p_cap_no_drive;
		@(posedge sys_clk) disable iff (!rst_b)
			cfgs[2].capture |=> !pin_en[2];
	endproperty
	a_cap_no_drive: assert property (p_cap_no_drive)
		else $error("Capture pin driven.");

	// The slave answers in the first access cycle.
	property p_apb_answer;
		@(posedge sys_clk) disable iff (!rst_b)
			psel && !penable |=> pready;
	endproperty
	a_apb_answer: assert property (p_apb_answer)
		else $error("Ready missing in access cycle.");

	// Ready stands for a single cycle.
	property p_apb_pulse;
		@(posedge sys_clk) disable iff (!rst_b)
			pready |=> !pready;
	endproperty
	a_apb_pulse: assert property (p_apb_pulse)
		else $error("Ready held too long.");

	// A read of channel 1 returns the stored control byte.
	property p_read_ch1;
		@(posedge sys_clk) disable iff (!rst_b)
			rd && paddr == tpio_pkg::OFF_IO_CONTROL_CH1
			|-> prdata == {24'h00_0000, io_control_ch1};
	endproperty
	a_read_ch1: assert property (p_read_ch1)
		else $error("Control read data wrong.");

endmodule // tpio_top

// file: include/tpio_pkg.sv
// Package of constants and types for the timer pin function control block.
package tpio_pkg;

	// ****************************************************************
	// Register map and field layout
	// ****************************************************************
	localparam logic [11:0] OFF_IO_CONTROL_CH1 = 12'h000;
	localparam logic [11:0] OFF_IO_CONTROL_CH2 = 12'h004;
	localparam logic [11:0] OFF_PIN_STATUS     = 12'h008;
	localparam logic [11:0] OFF_COUNTER        = 12'h00C;
	localparam logic [11:0] OFF_GEN_BASE       = 12'h010;
	localparam int          FIELD_A_LSB        = 0;
	localparam int          FIELD_B_LSB        = 4;
	localparam logic [7:0]  IO_CONTROL_RESET   = 8'h00;
	localparam logic [15:0] GEN_REG_RESET      = 16'hFFFF;
	localparam int          NUM_GEN            = 4;

	// ****************************************************************
	// Decoded function of one general register
	// ****************************************************************
	typedef enum logic [2:0] {
		FN_OFF,
		FN_CMP_LOW,
		FN_CMP_HIGH,
		FN_CMP_TOGGLE,
		FN_CAP_RISE,
		FN_CAP_FALL,
		FN_CAP_BOTH,
		FN_PROHIBITED
	} tpio_fn_type;

	// Setup carried to one pin unit.
	typedef struct packed {
		logic        capture;
		logic        init_level;
		tpio_fn_type fn;
	} tpio_cfg_type;

endpackage

// file: hdl/tpio_pin_unit.sv
// One general register with its pin: compare output or input capture.
`timescale 1ns/1ns
module tpio_pin_unit (
	input  wire logic                  sys_clk,   // System clock.
	input  wire logic                  rst_b,     // Sync reset, low.
	input  wire tpio_pkg::tpio_cfg_type cfg,      // Decoded field.
	input  wire logic                  cfg_load,  // Field just written.
	input  wire logic [15:0]           counter,   // Timer count.
	input  wire logic                  gen_wr,    // Software write.
	input  wire logic [15:0]           gen_wdata, // Write value.
	input  wire logic                  pin_in,    // Pin level in.
	output logic [15:0]                gen_value, // General register.
	output logic                       pin_out,   // Pin drive level.
	output logic                       pin_oe     // Pin output enable.
);

	logic pin_prev;
	logic match;
	logic rise;
	logic fall;
	logic hit;

	// Edge and match detection.
	assign match = (counter == gen_value) && !cfg.capture;
	assign rise  = pin_in && !pin_prev;
	assign fall  = !pin_in && pin_prev;
	always_comb begin
		case (cfg.fn)
			tpio_pkg::FN_CAP_RISE: hit = rise;
			tpio_pkg::FN_CAP_FALL: hit = fall;
			tpio_pkg::FN_CAP_BOTH: hit = rise || fall;
			default:               hit = 1'b0;
		endcase
	end

	// Previous pin level for edges.
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pin_prev <= 1'b0;
		end else begin
			pin_prev <= pin_in;
		end
	end

	// General register: software write, capture wins.
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			gen_value <= tpio_pkg::GEN_REG_RESET;
		end else if (hit) begin
			gen_value <= counter;
		end else if (gen_wr) begin
			gen_value <= gen_wdata;
		end
	end

	// Pin level: initial on setup, action on match.
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pin_out <= 1'b0;
			pin_oe  <= 1'b0;
		end else begin
			pin_oe <= !cfg.capture && (cfg.fn != tpio_pkg::FN_OFF);
			if (cfg_load) begin
				pin_out <= cfg.init_level;
			end else if (match) begin
				case (cfg.fn)
					tpio_pkg::FN_CMP_LOW:    pin_out <= 1'b0;
					tpio_pkg::FN_CMP_HIGH:   pin_out <= 1'b1;
					tpio_pkg::FN_CMP_TOGGLE: pin_out <= !pin_out;
					default:                 pin_out <= pin_out;
				endcase
			end
		end
	end

endmodule // tpio_pin_unit

// file: testbench/tpio_pin_model.sv
// Far-side model of the four timer pins.
`timescale 1ns/1ns
module tpio_pin_model (
	input  wire logic [3:0] pin_out,   // Device drive levels.
	input  wire logic [3:0] pin_oe,    // Device output enables.
	input  wire logic [3:0] ext_level, // Level of the outside driver.
	output logic [3:0]      pin_in     // Resolved pin levels.
);
	// A driven pin follows the device, a released one the outside.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
		end
	end
endmodule // tpio_pin_model

// file: testbench/tpio_top_tb.sv
// Self-checking bench for the timer pin function control block.
`timescale 1ns/1ns
module tpio_top_tb;
	logic        sys_clk = 1'b0;
	logic        rst_b   = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0000_0000;
	logic [15:0] counter = 16'h0000;
	logic [3:0]  ext     = 4'h0;
	logic [3:0]  pin_in;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [3:0]  pin_out;
	logic [3:0]  pin_oe;
	int          n_mismatch = 0;
	int          n_compared = 0;

	// ****************************************************************
	// Clock, design and pin model
	// ****************************************************************
	always #20 sys_clk = ~sys_clk;

	tpio_top DUT (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .counter(counter), .pin_in(pin_in),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_out(pin_out), .pin_oe(pin_oe));

	tpio_pin_model pins (.pin_out(pin_out), .pin_oe(pin_oe),
		.ext_level(ext), .pin_in(pin_in));

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic test_done();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask

	// One APB transfer; request held until pready is seen high.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic er);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 8);
		if (n >= 8) begin
			chk("pready", 32'h0000_0001, 32'h0000_0000);
			test_done();
		end
		q = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        er;
		apb(1'b1, a, d, q, er);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		logic        er;
		apb(1'b0, a, 32'h0000_0000, q, er);
		chk($sformatf("reg %h", a), e, q);
		chk("pslverr", 32'h0000_0000, {31'h0, er});
	endtask

	// Writes both control registers with field a low, field b high.
	task automatic set_ctl(input logic [3:0] a1, input logic [3:0] a2,
		input logic [3:0] b1, input logic [3:0] b2);
		wr(tpio_pkg::OFF_IO_CONTROL_CH1, {24'h0, b1, a1});
		wr(tpio_pkg::OFF_IO_CONTROL_CH2, {24'h0, b2, a2});
		repeat (4) @(posedge sys_clk);
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		logic [3:0]  f [4];
		logic [3:0]  eo;
		logic [3:0]  ev;
		logic [3:0]  ed;
		logic [31:0] q;
		logic        er;
		logic [15:0] eg;
		repeat (4) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		rd(tpio_pkg::OFF_IO_CONTROL_CH1, 32'h0000_0000);
		rd(tpio_pkg::OFF_IO_CONTROL_CH2, 32'h0000_0000);
		chk("oe after reset", 32'h0000_0000, {28'h0, pin_oe});
		rd(tpio_pkg::OFF_COUNTER, 32'h0000_0000);
		apb(1'b0, 12'h020, 32'h0000_0000, q, er);
		chk("unmapped error", 32'h0000_0001, {31'h0, er});
		chk("unmapped data", 32'h0000_0000, q);
		for (int i = 0; i < 4; i++) begin
			wr(tpio_pkg::OFF_GEN_BASE + 12'(4 * i), 32'h0000_0100);
			rd(tpio_pkg::OFF_GEN_BASE + 12'(4 * i), 32'h0000_0100);
		end
		// Every compare code, field b offset from field a.
		for (int c = 0; c < 8; c++) begin
			f[0] = 4'(c);
			f[1] = 4'((c + 3) % 8);
			f[2] = f[0];
			f[3] = f[1];
			set_ctl(f[0], f[2], f[1], f[3]);
			for (int i = 0; i < 4; i++) begin
				eo[i] = (f[i][1:0] != 2'b00);
				ev[i] = f[i][2] & eo[i];
			end
			chk("oe", {28'h0, eo}, {28'h0, pin_oe});
			chk("start level", {28'h0, ev}, {28'h0, pin_out & eo});
			counter <= 16'h0100;
			@(posedge sys_clk);
			counter <= 16'h0000;
			repeat (4) @(posedge sys_clk);
			for (int i = 0; i < 4; i++) begin
				ev[i] = f[i][1] & (f[i][0] ? ~ev[i] : 1'b1) & eo[i];
			end
			chk("match level", {28'h0, ev}, {28'h0, pin_out & eo});
			// Undriven units keep the start level that the write loaded.
			for (int i = 0; i < 4; i++) begin
				ed[i] = eo[i] ? ev[i] : f[i][2];
			end
			rd(tpio_pkg::OFF_PIN_STATUS, {24'h0, eo, ed});
		end
		// Capture codes; channel 1 never gets top bits 11.
		for (int m = 8; m < 16; m++) begin
			ext <= 4'h0;
			set_ctl(4'(m[2] ? m - 4 : m), 4'(m),
				4'(m[2] ? m - 4 : m), 4'(m));
			for (int i = 0; i < 4; i++) begin
				wr(tpio_pkg::OFF_GEN_BASE + 12'(4 * i), 32'h0000_0000);
			end
			counter <= 16'h1234;
			ext <= 4'hF;
			repeat (4) @(posedge sys_clk);
			eg = (m[1] | ~m[0]) ? 16'h1234 : 16'h0000;
			for (int i = 0; i < 4; i++) begin
				rd(tpio_pkg::OFF_GEN_BASE + 12'(4 * i), {16'h0, eg});
			end
			counter <= 16'h5678;
			ext <= 4'h0;
			repeat (4) @(posedge sys_clk);
			eg = (m[1] | m[0]) ? 16'h5678 : eg;
			for (int i = 0; i < 4; i++) begin
				rd(tpio_pkg::OFF_GEN_BASE + 12'(4 * i), {16'h0, eg});
			end
		end
		test_done();
	end
endmodule // tpio_top_tb
